// ===== inc/art_timer_regs.vh
/*
 * Register offsets, field positions and reset values of the auto-reload
 * timer. Assumes it is included by bare name from the design files.
 */
`ifndef ART_TIMER_REGS_VH
`define ART_TIMER_REGS_VH

// Register indices on the 4-bit register port
`define ADDR_CTRL     4'h0
`define ADDR_COUNTER  4'h1
`define ADDR_RELOAD   4'h2
`define ADDR_CAPCTRL  4'h3
`define ADDR_CAP0     4'h4
`define ADDR_CAP1     4'h5
`define ADDR_DUTY0    4'h6
`define ADDR_DUTY3    4'h9
`define ADDR_IRQSTAT  4'hA
`define ADDR_IRQMASK  4'hB

// Control/status register fields
`define CTRL_EXT_CLOCK_SELECT     7
`define CTRL_PS_HI    6
`define CTRL_PS_LO    4
`define CTRL_RUN      3
`define CTRL_FRL      2

// Capture control/status register fields
`define CAP_IE_HI     7
`define CAP_IE_LO     6
`define CAP_CS_HI     5
`define CAP_CS_LO     4

// Interrupt status bits
`define IRQ_OVF       0
`define IRQ_CAP0      1
`define IRQ_CAP1      2
`define IRQ_W         3

// Reset values and constants
`define RST_BYTE      8'h00
`define RST_PRE       7'h00
`define CNT_MAX       8'hFF
`define NUM_PWM       4
`define NUM_CAP       2

`endif

// ===== logic/capture_channel.v
/*
 * One input capture channel: pin synchroniser, edge select, value latch
 * and capture flag. Assumes the counter value and the read strobe come
 * from logic on the same core clock.
 */
`timescale 1ns/10ps
`include "art_timer_regs.vh"

module capture_channel (
	input  wire       i_core_clk,  // Core clock
	input  wire       i_rst_b,     // Async reset, active low
	input  wire       i_pin,       // Capture input pin, asynchronous
	input  wire       i_edge_sel,  // 1 rising, 0 falling
	input  wire [7:0] i_cnt,       // Live counter value
	input  wire       i_rd_clr,    // Read of the value register
	output reg  [7:0] o_value,     // Captured counter value
	output reg        o_flag,      // Capture flag
	output wire       o_event      // One-cycle active edge pulse
);

	reg        sync1_q;
	reg        sync2_q;
	reg        prev_q;
	wire       rise;
	wire       fall;

	//************************************************
	// Synchroniser and edge detect
	//************************************************

	// Two-flop synchroniser, then a history flop
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
		end else begin
			sync1_q <= i_pin;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	// Active edge chosen by software
	assign rise    = sync2_q & ~prev_q;
	assign fall    = ~sync2_q & prev_q;
	assign o_event = i_edge_sel ? rise : fall;

	//************************************************
	// Value latch and flag
	//************************************************

	// Latch only while the flag is clear; set wins over clear
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_value <= `RST_BYTE;
			o_flag  <= 1'b0;
		end else begin
			if (o_event && !o_flag) begin
				o_value <= i_cnt;
			end
			if (o_event) begin
				o_flag <= 1'b1;
			end else if (i_rd_clr) begin
				o_flag <= 1'b0;
			end
		end
	end

endmodule // capture_channel

// ===== logic/art_timer.v
/*
 * Auto-reload 8-bit timer with prescaler, four PWM compare channels and
 * two input capture channels, reached over a plain register port.
 * Assumes one core clock; the external count clock and capture pins are
 * asynchronous and are synchronised here.
 */
// Notes on behaviour
// - 8-bit up counter, ticks on prescaler output
// - Overflow reloads counter, prescaler left alone
// - Counter register reads live, writes immediate
// - 7-bit prescaler, divide by two power select
// - Select bit picks core or external clock
// - Run enable clear freezes prescaler and counter
// - Reset clears counter, prescaler, selects core clock
// - Force reload with run loads reload value
// - Counter initialisation also clears the prescaler
// - Four compare channels against shadow registers
// - Shadows load from duty registers at overflow
// - Active edge latches counter, sets flag
// - Per-channel rising or falling edge select
// - Enabled flag keeps interrupt request pending
// - Latch blocked until read; read clears flag
// - Enabled capture edge wakes device from halt
// - Halt capture with external clock may misread
`timescale 1ns/10ps
`include "art_timer_regs.vh"

module art_timer (
	input  wire       i_core_clk,  // Core clock, 125 MHz
	input  wire       i_rst_b,     // Async reset, active low
	input  wire [3:0] i_addr,      // Register index
	input  wire [7:0] i_wdata,     // Write data
	input  wire       i_wr,        // Write strobe
	input  wire       i_rd,        // Read strobe
	output reg  [7:0] o_rdata,     // Read data, cycle after strobe
	input  wire       i_ext_clk,   // External count clock pin
	input  wire [1:0] i_capture_input_pin, // Capture pins
	input  wire       i_halt,      // Device is in halt mode
	output wire [3:0] o_pwm_out_n, // PWM outputs, channel n
	output wire       o_irq,       // Level interrupt
	output wire       o_wake       // Halt wake request
);

	//************************************************
	// Declarations
	//************************************************

	reg        ext_clock_select_q;
	reg  [2:0] prescale_select_q;
	reg        counter_run_enable_q;
	reg  [6:0] pre_q;
	reg  [7:0] cnt_q;
	reg  [7:0] auto_reload_reg_q;
	reg  [7:0] duty_cycle_reg_q [0:3];
	reg  [7:0] compare_shadow_reg_q [0:3];
	reg  [3:0] pwm_q;
	reg  [1:0] capture_irq_enable_q;
	reg  [1:0] capture_edge_select_q;
	reg  [`IRQ_W-1:0] irq_stat_q;
	reg  [`IRQ_W-1:0] irq_mask_q;
	reg        ext1_q;
	reg        ext2_q;
	reg        ext3_q;
	wire       src_tick;
	wire       cnt_tick;
	wire       ovf;
	wire       wr_ctrl;
	wire       wr_cnt;
	wire       force_ld;
	wire [1:0] cap_flag;
	wire [1:0] cap_evt;
	wire [7:0] cap_val0;
	wire [7:0] cap_val1;
	wire [1:0] cap_rd;
	wire       duty_wr;
	wire [1:0] duty_idx;
	wire [3:0] duty_off;
	reg  [7:0] rd_mux;
	integer    i;

	//************************************************
	// Helper functions
	//************************************************

	// Tap of the prescaler: low sel bits all ones gives a carry
	function tap_hit;
		input [6:0] pre;
		input [2:0] sel;
		reg   [6:0] msk;
		begin
			msk     = ~(7'h7F << sel);
			tap_hit = ((pre & msk) == msk);
		end
	endfunction

	// Register decode against a strobe
	function hit;
		input [3:0] addr;
		input [3:0] reg_addr;
		input       strobe;
		begin
			hit = strobe && (addr == reg_addr);
		end
	endfunction

	//************************************************
	// Write decode
	//************************************************

	assign wr_ctrl  = hit(i_addr, `ADDR_CTRL, i_wr);
	assign wr_cnt   = hit(i_addr, `ADDR_COUNTER, i_wr);
	assign force_ld = wr_ctrl && i_wdata[`CTRL_FRL]
	                  && i_wdata[`CTRL_RUN];
	assign duty_wr  = i_wr && (i_addr >= `ADDR_DUTY0)
	                  && (i_addr <= `ADDR_DUTY3);
	assign duty_off = i_addr - `ADDR_DUTY0;
	assign duty_idx = duty_off[1:0];
	assign cap_rd[0] = hit(i_addr, `ADDR_CAP0, i_rd);
	assign cap_rd[1] = hit(i_addr, `ADDR_CAP1, i_rd);

	//************************************************
	// External count clock synchroniser
	//************************************************

	// Two flops, then history for rising edge detect
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ext1_q <= 1'b0;
			ext2_q <= 1'b0;
			ext3_q <= 1'b0;
		end else begin
			ext1_q <= i_ext_clk;
			ext2_q <= ext1_q;
			ext3_q <= ext2_q;
		end
	end

	// Prescaler source: every core cycle or external rising edge
	assign src_tick = ext_clock_select_q ? (ext2_q & ~ext3_q)
	                                     : 1'b1;

	// Counter clock from the selected prescaler tap
	assign cnt_tick = counter_run_enable_q && src_tick
	                  && tap_hit(pre_q, prescale_select_q);
	assign ovf      = cnt_tick && (cnt_q == `CNT_MAX);

	//************************************************
	// Control register
	//************************************************

	// Clock select, prescale select and run enable
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ext_clock_select_q   <= 1'b0;
			prescale_select_q    <= 3'h0;
			counter_run_enable_q <= 1'b0;
		end else if (wr_ctrl) begin
			ext_clock_select_q   <= i_wdata[`CTRL_EXT_CLOCK_SELECT];
			prescale_select_q    <= i_wdata[`CTRL_PS_HI:`CTRL_PS_LO];
			counter_run_enable_q <= i_wdata[`CTRL_RUN];
		end
	end

	//************************************************
	// Prescaler and counter
	//************************************************

	// Prescaler; cleared on any counter initialisation
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pre_q <= `RST_PRE;
		end else if (wr_cnt || force_ld) begin
			pre_q <= `RST_PRE;
		end else if (counter_run_enable_q && src_tick) begin
			pre_q <= pre_q + 7'h01;
		end
	end

	// Counter: software writes win over a tick in the same cycle
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_q <= `RST_BYTE;
		end else if (wr_cnt) begin
			cnt_q <= i_wdata;
		end else if (force_ld) begin
			cnt_q <= auto_reload_reg_q;
		end else if (ovf) begin
			cnt_q <= auto_reload_reg_q;
		end else if (cnt_tick) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	// Auto-reload value
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			auto_reload_reg_q <= `RST_BYTE;
		end else if (hit(i_addr, `ADDR_RELOAD, i_wr)) begin
			auto_reload_reg_q <= i_wdata;
		end
	end

	//************************************************
	// Compare channels and PWM
	//************************************************

	// Duty registers, shadows loaded at overflow, PWM levels
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (i = 0; i < `NUM_PWM; i = i + 1) begin
				duty_cycle_reg_q[i]     <= `RST_BYTE;
				compare_shadow_reg_q[i] <= `RST_BYTE;
			end
			pwm_q <= 4'h0;
		end else begin
			if (duty_wr) begin
				duty_cycle_reg_q[duty_idx] <= i_wdata;
			end
			for (i = 0; i < `NUM_PWM; i = i + 1) begin
				if (ovf) begin
					compare_shadow_reg_q[i] <=
						duty_cycle_reg_q[i];
					pwm_q[i] <= 1'b1;
				end else if (cnt_tick && ((cnt_q + 8'h01)
				             == compare_shadow_reg_q[i])) begin
					pwm_q[i] <= 1'b0;
				end
			end
		end
	end

	assign o_pwm_out_n = pwm_q;

	//************************************************
	// Capture channels
	//************************************************

	// Edge selects and interrupt enables
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			capture_irq_enable_q  <= 2'h0;
			capture_edge_select_q <= 2'h0;
		end else if (hit(i_addr, `ADDR_CAPCTRL, i_wr)) begin
			capture_irq_enable_q  <= i_wdata[`CAP_IE_HI:`CAP_IE_LO];
			capture_edge_select_q <= i_wdata[`CAP_CS_HI:`CAP_CS_LO];
		end
	end

	// Capture latches the live counter; a capture coinciding with an
	// external clock edge in halt may catch a counter in transition
	capture_channel u_cap0 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_pin      (i_capture_input_pin[0]),
		.i_edge_sel (capture_edge_select_q[0]),
		.i_cnt      (cnt_q),
		.i_rd_clr   (cap_rd[0]),
		.o_value    (cap_val0),
		.o_flag     (cap_flag[0]),
		.o_event    (cap_evt[0])
	);

	capture_channel u_cap1 (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_pin      (i_capture_input_pin[1]),
		.i_edge_sel (capture_edge_select_q[1]),
		.i_cnt      (cnt_q),
		.i_rd_clr   (cap_rd[1]),
		.o_value    (cap_val1),
		.o_flag     (cap_flag[1]),
		.o_event    (cap_evt[1])
	);

	//************************************************
	// Interrupt status and mask
	//************************************************

	// Sticky events, write one to clear; a new event wins
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			irq_stat_q <= 3'h0;
			irq_mask_q <= 3'h0;
		end else begin
			if (hit(i_addr, `ADDR_IRQMASK, i_wr)) begin
				irq_mask_q <= i_wdata[`IRQ_W-1:0];
			end
			irq_stat_q <= (irq_stat_q
				& ~({`IRQ_W{hit(i_addr, `ADDR_IRQSTAT, i_wr)}}
				    & i_wdata[`IRQ_W-1:0]))
				| {cap_evt, ovf};
		end
	end

	// Capture requests stay pending while flag and enable are set
	assign o_irq  = (|(irq_stat_q & irq_mask_q))
	                | (|(cap_flag & capture_irq_enable_q));
	assign o_wake = i_halt
	                && (|(cap_flag & capture_irq_enable_q));

	//************************************************
	// Read path
	//************************************************

	// Read multiplexer; unmapped indices read zero
	always @* begin
		rd_mux = `RST_BYTE;
		case (i_addr)
		`ADDR_CTRL: begin
			rd_mux = {ext_clock_select_q, prescale_select_q,
			          counter_run_enable_q, 3'h0};
		end
		`ADDR_COUNTER: begin
			rd_mux = cnt_q;
		end
		`ADDR_RELOAD: begin
			rd_mux = auto_reload_reg_q;
		end
		`ADDR_CAPCTRL: begin
			rd_mux = {capture_irq_enable_q, capture_edge_select_q,
			          2'h0, cap_flag};
		end
		`ADDR_CAP0: begin
			rd_mux = cap_val0;
		end
		`ADDR_CAP1: begin
			rd_mux = cap_val1;
		end
		`ADDR_IRQSTAT: begin
			rd_mux = {5'h00, irq_stat_q};
		end
		`ADDR_IRQMASK: begin
			rd_mux = {5'h00, irq_mask_q};
		end
		default: begin
			if (i_addr >= `ADDR_DUTY0 && i_addr <= `ADDR_DUTY3) begin
				rd_mux = duty_cycle_reg_q[duty_idx];
			end
		end
		endcase
	end

	// Read data registered, valid only the cycle after the strobe
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= `RST_BYTE;
		end else if (i_rd) begin
			o_rdata <= rd_mux;
		end else begin
			o_rdata <= `RST_BYTE;
		end
	end

endmodule // art_timer

// ===== bench/pulse_source.sv
/* Far side model: external count clock and the two capture pins.
   Assumes the bench asks for pin levels and clock bursts. */
`timescale 1ns/10ps
module pulse_source (
	input  wire logic       i_ext_on,  // Run external clock
	input  wire logic [1:0] i_lvl,     // Wanted pin levels
	output logic            o_ext_clk, // External count clock
	output logic [1:0]      o_pins     // Capture pins
);
	// Clock unrelated to core, stands low outside bursts
	initial o_ext_clk = 1'b0;
	always #33 o_ext_clk = i_ext_on ? ~o_ext_clk : 1'b0;
	// Pins follow the asked levels
	assign o_pins = i_lvl;
endmodule // pulse_source

// ===== bench/art_timer_properties.sv
/* Port checker of art_timer.
   Assumes it is bound to art_timer and sees one core clock. */
`timescale 1ns/10ps
module art_timer_properties (
	input wire logic       i_core_clk,          // Clock
	input wire logic       i_rst_b,             // Reset
	input wire logic [3:0] i_addr,              // Index
	input wire logic [7:0] i_wdata,             // Write data
	input wire logic       i_wr,                // Write
	input wire logic       i_rd,                // Read
	input wire logic [7:0] o_rdata,             // Read data
	input wire logic       i_ext_clk,           // Ext clock
	input wire logic [1:0] i_capture_input_pin, // Pins
	input wire logic       i_halt,              // Halt
	input wire logic [3:0] o_pwm_out_n,         // PWM
	input wire logic       o_irq,               // Interrupt
	input wire logic       o_wake               // Wake
);
	logic [7:3] ctrl_q;
	logic [7:0] reload_q;
	logic [7:0] duty_q [0:3];
	logic [2:0] mask_q;
	logic [1:0] capie_q;
	logic [7:0] duty_sel;

	// Copy of software writes
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_q   <= 5'h00;
			reload_q <= 8'h00;
			duty_q   <= '{default: 8'h00};
			mask_q   <= 3'h0;
			capie_q  <= 2'h0;
		end else if (i_wr) begin
			case (i_addr)
			4'h0: ctrl_q <= i_wdata[7:3];
			4'h2: reload_q <= i_wdata;
			4'h3: capie_q <= i_wdata[7:6];
			4'h6, 4'h7, 4'h8, 4'h9: duty_q[i_addr[1:0] - 2'h2] <= i_wdata;
			4'hB: mask_q <= i_wdata[2:0];
			default: ;
			endcase
		end
	end
	// Duty register under the current index
	assign duty_sel = duty_q[i_addr[1:0] - 2'h2];

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);

	a_rdata_idle: assert property (
		!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("Read data outside reply");
	a_unmapped_zero: assert property (
		$past(i_rd && i_addr > 4'hB) |-> o_rdata == 8'h00)
		else $error("Unmapped read not zero");
	a_ctrl_readback: assert property (
		$past(i_rd && i_addr == 4'h0) |-> o_rdata[7:2] == {$past(ctrl_q), 1'b0})
		else $error("Control readback wrong");
	a_reload_readback: assert property (
		$past(i_rd && i_addr == 4'h2) |-> o_rdata == $past(reload_q))
		else $error("Reload readback wrong");
	a_duty_readback: assert property (
		$past(i_rd && i_addr >= 4'h6 && i_addr <= 4'h9)
		|-> o_rdata == $past(duty_sel))
		else $error("Duty readback wrong");
	a_pwm_frozen: assert property (
		!ctrl_q[3] && !$past(ctrl_q[3]) && !$past(ctrl_q[3], 2)
		|-> $stable(o_pwm_out_n))
		else $error("PWM moved while stopped");
	a_irq_masked: assert property (
		mask_q == 3'h0 && capie_q == 2'h0 |-> !o_irq)
		else $error("Interrupt with all sources off");
	a_wake_cause: assert property (
		o_wake |-> i_halt && o_irq && capie_q != 2'h0)
		else $error("Wake without cause");

	c_wake: cover property (o_wake);
	c_irq: cover property (o_irq);
	c_pwm_fall: cover property ($fell(o_pwm_out_n[0]));
endmodule // art_timer_properties

bind art_timer art_timer_properties u_art_timer_properties (
	.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_ext_clk(i_ext_clk), .i_capture_input_pin(i_capture_input_pin),
	.i_halt(i_halt), .o_pwm_out_n(o_pwm_out_n), .o_irq(o_irq),
	.o_wake(o_wake)
);

// ===== bench/test_art_timer.sv
/* Self-checking bench of art_timer through its register port.
   Assumes pulse_source drives the external clock and capture pins. */
`timescale 1ns/10ps
module test_art_timer;
	logic       i_core_clk = 1'b0;
	logic       i_rst_b = 1'b0;
	logic       i_wr = 1'b0;
	logic       i_rd = 1'b0;
	logic       i_halt = 1'b0;
	logic       ext_on = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00;
	logic [1:0] lvl = 2'b10;
	logic [7:0] o_rdata;
	logic [3:0] o_pwm_out_n;
	logic [1:0] pins;
	logic       o_irq, o_wake, ext_clk;
	int         err_count = 0, check_count = 0, cyc = 0;

	art_timer u_art_timer (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_ext_clk(ext_clk), .i_capture_input_pin(pins),
		.i_halt(i_halt), .o_pwm_out_n(o_pwm_out_n), .o_irq(o_irq),
		.o_wake(o_wake));
	pulse_source u_pulse_source (.i_ext_on(ext_on), .i_lvl(lvl),
		.o_ext_clk(ext_clk), .o_pins(pins));

	// 125 MHz clock and hang guard
	always #4 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			err_count++;
			test_done;
		end
	end

	task test_done;
		$display("Checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("Error at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task rc(input logic [3:0] a, input logic [7:0] e);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, e);
	endtask
	// Run d cycles with control c, then stop
	task run(input logic [7:0] c, input int d);
		wr(4'h0, c);
		repeat (d - 2) @(posedge i_core_clk);
		wr(4'h0, 8'h00);
	endtask
	task pause;
		repeat (6) @(posedge i_core_clk);
	endtask

	initial begin
		repeat (20) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		rc(4'h0, 8'h00);
		rc(4'h1, 8'h00);
		// Every prescaler tap, counter write clears prescaler
		for (int n = 0; n < 8; n++) begin
			wr(4'h1, 8'h00);
			run({1'b0, n[2:0], 4'h8}, n ? 5 << (n - 1) : 5);
			rc(4'h1, n ? 8'h02 : 8'h05);
		end
		// External source, counting from zero
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h88);
		pause;
		rc(4'h1, 8'h00);
		ext_on <= 1'b1;
		run(8'h88, 80);
		ext_on <= 1'b0;
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= 4'h1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 chk({7'h00, o_rdata inside {[8'h08:8'h0B]}}, 8'h01);
		// Overflow, reload, shadows and PWM
		wr(4'h2, 8'hF0);
		wr(4'h6, 8'hF4);
		wr(4'h7, 8'hF8);
		wr(4'h8, 8'hFC);
		wr(4'h9, 8'h00);
		wr(4'hB, 8'h01);
		wr(4'h1, 8'hFE);
		run(8'h08, 8);
		rc(4'h1, 8'hF6);
		chk({4'h0, o_pwm_out_n}, 8'h0E);
		rc(4'hA, 8'h01);
		chk({7'h00, o_irq}, 8'h01);
		wr(4'hB, 8'h00);
		chk({7'h00, o_irq}, 8'h00);
		wr(4'hA, 8'h01);
		rc(4'hA, 8'h00);
		wr(4'h7, 8'hFA);
		run(8'h08, 3);
		chk({4'h0, o_pwm_out_n}, 8'h0C);
		run(8'h08, 16);
		chk({4'h0, o_pwm_out_n}, 8'h0E);
		// Forced reload needs run
		wr(4'h1, 8'h33);
		wr(4'h0, 8'h04);
		rc(4'h1, 8'h33);
		run(8'h0C, 2);
		rc(4'h1, 8'hF2);
		// Capture, blocking, edge select, wake
		wr(4'h1, 8'h55);
		i_halt <= 1'b1;
		wr(4'h3, 8'h50);
		lvl[0] <= 1'b1;
		pause;
		rc(4'h3, 8'h51);
		chk({6'h00, o_wake, o_irq}, 8'h03);
		wr(4'h1, 8'h77);
		lvl[0] <= 1'b0;
		pause;
		lvl[0] <= 1'b1;
		pause;
		rc(4'h4, 8'h55);
		rc(4'h3, 8'h50);
		chk({6'h00, o_wake, o_irq}, 8'h00);
		lvl[1] <= 1'b0;
		pause;
		rc(4'h3, 8'h52);
		chk({7'h00, o_irq}, 8'h00);
		rc(4'h5, 8'h77);
		lvl[1] <= 1'b1;
		pause;
		rc(4'h3, 8'h50);
		wr(4'hD, 8'hFF);
		rc(4'hC, 8'h00);
		test_done;
	end
endmodule // test_art_timer
